// ==== src/rbf_regfile.sv ====
// Banked register file with special register aliases and address mapping
module rbf_regfile
#(
  parameter logic [7:0] STACK_RESET = 8'h00
)
(
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        bank_select_high_in,
  input  wire logic        bank_select_low_in,
  input  wire logic        rf_rd_en_in,
  input  wire logic        rf_wr_en_in,
  input  wire logic [5:0]  rf_loc_in,
  input  wire logic [1:0]  rf_size_in,
  input  wire logic [31:0] rf_wdata_in,
  output logic             rf_ack_out,
  output logic             rf_err_out,
  output logic      [31:0] rf_rdata_out,
  input  wire logic        sfr_rd_en_in,
  input  wire logic        sfr_wr_en_in,
  input  wire logic [8:0]  sfr_addr_in,
  input  wire logic [7:0]  sfr_wdata_in,
  output logic             sfr_ack_out,
  output logic             sfr_hit_out,
  output logic      [7:0]  sfr_rdata_out,
  input  wire logic        mem_rd_en_in,
  input  wire logic        mem_wr_en_in,
  input  wire logic [23:0] mem_addr_in,
  input  wire logic [7:0]  mem_wdata_in,
  output logic             mem_ack_out,
  output logic             mem_hit_out,
  output logic      [7:0]  mem_rdata_out,
  input  wire logic        map_valid_in,
  input  wire logic [1:0]  map_space_in,
  input  wire logic [15:0] map_offset_in,
  output logic             map_valid_out,
  output logic      [23:0] map_addr_out,
  input  wire logic        stack_push_in,
  input  wire logic        stack_pop_in,
  output logic      [15:0] stack_pointer_out,
  output logic      [15:0] legacy_data_pointer_out,
  output logic      [7:0]  data_pointer_region_out
);
  localparam int NB  = rbf_pkg::FF_BYTES;
  localparam int SL  = rbf_pkg::SFR_LAT;

  if (rbf_pkg::SFR_LAT <= rbf_pkg::RF_LAT)
  begin : g_chk
    $error("alias path must be slower than register path");
  end

  function automatic logic [4:0] ff_idx(input logic [5:0] loc);
    if (loc >= rbf_pkg::LOC_XDP_BASE)
      ff_idx = 5'(loc - rbf_pkg::LOC_XDP_BASE + rbf_pkg::FF_HI_SLOT);
    else
      ff_idx = 5'(loc - rbf_pkg::FF_BASE);
  endfunction

  function automatic logic [2:0] nbytes(input logic [1:0] sz);
    case (sz)
      rbf_pkg::SZ_WORD:  nbytes = 3'h2;
      rbf_pkg::SZ_DWORD: nbytes = 3'h4;
      default:           nbytes = 3'h1;
    endcase
  endfunction

  function automatic logic legal(input logic [5:0] loc,
                                 input logic [1:0] sz);
    case (sz)
      rbf_pkg::SZ_BYTE:  legal = loc <= rbf_pkg::BYTE_END;
      rbf_pkg::SZ_WORD:  legal = loc < rbf_pkg::LOW_END && !loc[0];
      rbf_pkg::SZ_DWORD: legal = (loc < rbf_pkg::LOW_END && loc[1:0] == 2'h0)
                                 || loc == rbf_pkg::LOC_XDP_BASE
                                 || loc == rbf_pkg::LOC_STK_BASE;
      default:           legal = 1'b0;
    endcase
  endfunction

  // Returns {hit, location}; location 56 and 60-61 have no alias
  function automatic logic [6:0] sfr_map(input logic [8:0] a);
    case (a)
      rbf_pkg::SFR_STK_LO: sfr_map = {1'b1, rbf_pkg::LOC_STK_LO};
      rbf_pkg::SFR_STK_HI: sfr_map = {1'b1, rbf_pkg::LOC_STK_HI};
      rbf_pkg::SFR_PTR_LO: sfr_map = {1'b1, rbf_pkg::LOC_PTR_LO};
      rbf_pkg::SFR_PTR_HI: sfr_map = {1'b1, rbf_pkg::LOC_PTR_HI};
      rbf_pkg::SFR_REGION: sfr_map = {1'b1, rbf_pkg::LOC_REGION};
      rbf_pkg::SFR_ACC:    sfr_map = {1'b1, rbf_pkg::LOC_ACC};
      rbf_pkg::SFR_OPB:    sfr_map = {1'b1, rbf_pkg::LOC_OPB};
      default:             sfr_map = 7'h00;
    endcase
  endfunction

  logic [7:0]  ff_q [NB];
  logic [7:0]  ff_d [NB];
  logic [1:0]  bank;
  logic        rf_ok;
  logic        rf_wr_go;
  logic        rf_bank_wr;
  logic [6:0]  sfr_sel;
  logic        sfr_wr_go;
  logic        mem_hit;
  logic        mem_wr_go;
  logic        ram_we;
  logic [1:0]  ram_wr_row;
  logic [7:0]  ram_be;
  logic [63:0] ram_wdata;
  logic [63:0] ram_rd_a;
  logic [63:0] ram_rd_b;

  assign bank       = {bank_select_high_in, bank_select_low_in};
  assign rf_ok      = legal(rf_loc_in, rf_size_in)
                      && !(rf_rd_en_in && rf_wr_en_in);
  assign rf_wr_go   = rf_wr_en_in && rf_ok;
  assign rf_bank_wr = rf_wr_go && rf_loc_in <= rbf_pkg::BANK_END;
  assign sfr_sel    = sfr_map(sfr_addr_in);
  assign sfr_wr_go  = sfr_wr_en_in && !sfr_rd_en_in && sfr_sel[6];
  assign mem_hit    = mem_addr_in < rbf_pkg::BANK_MEM_LIM;
  // Register-view bank writes win the single RAM write port
  assign mem_wr_go  = mem_wr_en_in && !mem_rd_en_in && mem_hit
                      && !rf_bank_wr;
  assign ram_we     = rf_bank_wr || mem_wr_go;
  assign ram_wr_row = rf_bank_wr ? bank
                      : mem_addr_in[rbf_pkg::ROW_LSB +: rbf_pkg::ROW_W];

  rbf_bank_ram #(
    .ROWS  (4),
    .LANES (8)
  ) u_ram (
    .clk_in      (clk_in),
    .we_in       (ram_we),
    .wr_row_in   (ram_wr_row),
    .be_in       (ram_be),
    .wdata_in    (ram_wdata),
    .rd_row_a_in (bank),
    .rd_row_b_in (mem_addr_in[rbf_pkg::ROW_LSB +: rbf_pkg::ROW_W]),
    .rdata_a_out (ram_rd_a),
    .rdata_b_out (ram_rd_b)
  );

  // Storage: stack adjust, then alias write, then register-view write
  always_comb
  begin
    logic [31:0] wal;
    logic [15:0] stk;
    logic [5:0]  li;
    wal = 32'h0;
    li  = 6'h0;
    ff_d = ff_q;
    ram_be = 8'h00;
    ram_wdata = 64'h0;
    stk = {ff_q[ff_idx(rbf_pkg::LOC_STK_HI)],
           ff_q[ff_idx(rbf_pkg::LOC_STK_LO)]};
    if (stack_push_in && !stack_pop_in)
      stk = stk + rbf_pkg::STACK_STEP;
    else if (stack_pop_in && !stack_push_in)
      stk = stk - rbf_pkg::STACK_STEP;
    ff_d[ff_idx(rbf_pkg::LOC_STK_HI)] = stk[15:8];
    ff_d[ff_idx(rbf_pkg::LOC_STK_LO)] = stk[7:0];
    if (sfr_wr_go)
      ff_d[ff_idx(sfr_sel[5:0])] = sfr_wdata_in;
    case (rf_size_in)
      rbf_pkg::SZ_WORD:  wal = {rf_wdata_in[15:0], 16'h0};
      rbf_pkg::SZ_DWORD: wal = rf_wdata_in;
      default:           wal = {rf_wdata_in[7:0], 24'h0};
    endcase
    // Most significant byte lands on the named location
    for (int i = 0; i < 4; i++)
    begin
      if (rf_wr_go && 3'(i) < nbytes(rf_size_in))
      begin
        li = 6'(rf_loc_in + 6'(i));
        if (li <= rbf_pkg::BANK_END)
        begin
          ram_be[li[2:0]] = 1'b1;
          ram_wdata[8*li[2:0] +: 8] = wal[31-8*i -: 8];
        end
        else
          ff_d[ff_idx(li)] = wal[31-8*i -: 8];
      end
    end
    if (mem_wr_go)
    begin
      ram_be[mem_addr_in[rbf_pkg::LANE_W-1:0]] = 1'b1;
      ram_wdata[8*mem_addr_in[rbf_pkg::LANE_W-1:0] +: 8] = mem_wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      for (int k = 0; k < NB; k++)
        ff_q[k] <= rbf_pkg::REG_RESET;
      ff_q[ff_idx(rbf_pkg::LOC_REGION)] <= rbf_pkg::REGION_RESET;
      ff_q[ff_idx(rbf_pkg::LOC_STK_LO)] <= STACK_RESET;
    end
    else
      ff_q <= ff_d;
  end

  assign stack_pointer_out       = {ff_q[ff_idx(rbf_pkg::LOC_STK_HI)],
                                    ff_q[ff_idx(rbf_pkg::LOC_STK_LO)]};
  assign legacy_data_pointer_out = {ff_q[ff_idx(rbf_pkg::LOC_PTR_HI)],
                                    ff_q[ff_idx(rbf_pkg::LOC_PTR_LO)]};
  assign data_pointer_region_out = ff_q[ff_idx(rbf_pkg::LOC_REGION)];

  // Register-view read pipeline: flops sampled at request, RAM row later
  logic        rf1_vld_q, rf1_vld_d, rf1_rd_q, rf1_rd_d;
  logic        rf1_err_q, rf1_err_d, rf1_bank_q, rf1_bank_d;
  logic [2:0]  rf1_lane_q, rf1_lane_d;
  logic [1:0]  rf1_size_q, rf1_size_d;
  logic [31:0] rf1_ff_q, rf1_ff_d;
  logic        rf_ack_q, rf_ack_d, rf_err_q, rf_err_d;
  logic [31:0] rf_rdata_q, rf_rdata_d;

  always_comb
  begin
    logic [31:0] al;
    logic [5:0]  li;
    al = 32'h0;
    li = 6'h0;
    rf1_vld_d  = rf_rd_en_in || rf_wr_en_in;
    rf1_rd_d   = rf_rd_en_in && !rf_wr_en_in;
    rf1_err_d  = rf1_vld_d && !rf_ok;
    rf1_bank_d = rf_loc_in <= rbf_pkg::BANK_END;
    rf1_lane_d = rf_loc_in[2:0];
    rf1_size_d = rf_size_in;
    rf1_ff_d   = 32'h0;
    for (int i = 0; i < 4; i++)
    begin
      li = 6'(rf_loc_in + 6'(i));
      if (3'(i) < nbytes(rf_size_in) && li > rbf_pkg::BANK_END && rf_ok)
        rf1_ff_d[31-8*i -: 8] = ff_q[ff_idx(li)];
    end
    al = rf1_ff_q;
    if (rf1_bank_q)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (3'(i) < nbytes(rf1_size_q))
          al[31-8*i -: 8] = ram_rd_a[8*(3'(rf1_lane_q + 3'(i))) +: 8];
      end
    end
    rf_ack_d   = rf1_vld_q;
    rf_err_d   = rf1_vld_q && rf1_err_q;
    rf_rdata_d = 32'h0;
    if (rf1_vld_q && rf1_rd_q && !rf1_err_q)
    begin
      case (rf1_size_q)
        rbf_pkg::SZ_WORD:  rf_rdata_d = {16'h0, al[31:16]};
        rbf_pkg::SZ_DWORD: rf_rdata_d = al;
        default:           rf_rdata_d = {24'h0, al[31:24]};
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rf1_vld_q  <= 1'b0;
      rf1_rd_q   <= 1'b0;
      rf1_err_q  <= 1'b0;
      rf1_bank_q <= 1'b0;
      rf1_lane_q <= 3'h0;
      rf1_size_q <= 2'h0;
      rf1_ff_q   <= 32'h0;
      rf_ack_q   <= 1'b0;
      rf_err_q   <= 1'b0;
      rf_rdata_q <= 32'h0;
    end
    else
    begin
      rf1_vld_q  <= rf1_vld_d;
      rf1_rd_q   <= rf1_rd_d;
      rf1_err_q  <= rf1_err_d;
      rf1_bank_q <= rf1_bank_d;
      rf1_lane_q <= rf1_lane_d;
      rf1_size_q <= rf1_size_d;
      rf1_ff_q   <= rf1_ff_d;
      rf_ack_q   <= rf_ack_d;
      rf_err_q   <= rf_err_d;
      rf_rdata_q <= rf_rdata_d;
    end
  end

  assign rf_ack_out   = rf_ack_q;
  assign rf_err_out   = rf_err_q;
  assign rf_rdata_out = rf_rdata_q;

  // Alias path is a longer delay line, one state behind the register view
  logic       sv_q [SL];
  logic       sv_d [SL];
  logic       sh_q [SL];
  logic       sh_d [SL];
  logic [7:0] sd_q [SL];
  logic [7:0] sd_d [SL];

  always_comb
  begin
    sv_d[0] = sfr_rd_en_in || sfr_wr_en_in;
    sh_d[0] = sfr_sel[6];
    sd_d[0] = (sfr_rd_en_in && !sfr_wr_en_in && sfr_sel[6])
              ? ff_q[ff_idx(sfr_sel[5:0])] : 8'h00;
    for (int s = 1; s < SL; s++)
    begin
      sv_d[s] = sv_q[s-1];
      sh_d[s] = sh_q[s-1];
      sd_d[s] = sd_q[s-1];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      for (int s = 0; s < SL; s++)
      begin
        sv_q[s] <= 1'b0;
        sh_q[s] <= 1'b0;
        sd_q[s] <= 8'h00;
      end
    end
    else
    begin
      sv_q <= sv_d;
      sh_q <= sh_d;
      sd_q <= sd_d;
    end
  end

  assign sfr_ack_out   = sv_q[SL-1];
  assign sfr_hit_out   = sh_q[SL-1];
  assign sfr_rdata_out = sd_q[SL-1];

  // Memory view of the banks and the unified-space address mapper
  logic       m1_vld_q, m1_vld_d, m1_ok_q, m1_ok_d, m1_rd_q, m1_rd_d;
  logic [2:0] m1_lane_q, m1_lane_d;
  logic       m_ack_q, m_ack_d, m_hit_q, m_hit_d;
  logic [7:0] m_dat_q, m_dat_d;
  logic        mv_q, mv_d;
  logic [23:0] ma_q, ma_d;

  always_comb
  begin
    m1_vld_d  = mem_rd_en_in || mem_wr_en_in;
    m1_rd_d   = mem_rd_en_in && !mem_wr_en_in;
    m1_ok_d   = mem_hit && (m1_rd_d || mem_wr_go);
    m1_lane_d = mem_addr_in[rbf_pkg::LANE_W-1:0];
    m_ack_d   = m1_vld_q && (m1_ok_q || !m1_rd_q && !m1_ok_q && 1'b0)
                || m1_vld_q && m1_rd_q;
    m_hit_d   = m1_vld_q && m1_ok_q;
    m_dat_d   = (m1_vld_q && m1_rd_q && m1_ok_q)
                ? ram_rd_b[8*m1_lane_q +: 8] : 8'h00;
    mv_d = map_valid_in;
    ma_d = 24'h0;
    if (map_valid_in)
    begin
      case (map_space_in)
        rbf_pkg::SPACE_CODE:  ma_d = {rbf_pkg::REGION_CODE, map_offset_in};
        rbf_pkg::SPACE_XDATA: ma_d = {ff_q[ff_idx(rbf_pkg::LOC_REGION)],
                                      map_offset_in};
        rbf_pkg::SPACE_IDATA: ma_d = {rbf_pkg::REGION_IDATA, map_offset_in};
        default:              ma_d = {16'h0, map_offset_in[7:0]};
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      m1_vld_q  <= 1'b0;
      m1_ok_q   <= 1'b0;
      m1_rd_q   <= 1'b0;
      m1_lane_q <= 3'h0;
      m_ack_q   <= 1'b0;
      m_hit_q   <= 1'b0;
      m_dat_q   <= 8'h00;
      mv_q      <= 1'b0;
      ma_q      <= 24'h0;
    end
    else
    begin
      m1_vld_q  <= m1_vld_d;
      m1_ok_q   <= m1_ok_d;
      m1_rd_q   <= m1_rd_d;
      m1_lane_q <= m1_lane_d;
      m_ack_q   <= m_ack_d;
      m_hit_q   <= m_hit_d;
      m_dat_q   <= m_dat_d;
      mv_q      <= mv_d;
      ma_q      <= ma_d;
    end
  end

  assign mem_ack_out   = m_ack_q;
  assign mem_hit_out   = m_hit_q;
  assign mem_rdata_out = m_dat_q;
  assign map_valid_out = mv_q;
  assign map_addr_out  = ma_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence rf_read_s;
    rf_rd_en_in && !rf_wr_en_in && !sfr_rd_en_in;
  endsequence

  sequence sfr_read_s;
    sfr_rd_en_in && !sfr_wr_en_in;
  endsequence

  rf_answer_a: assert property (rf_read_s |-> ##2 rf_ack_out)
    else $error("register read not answered in two cycles");
  reserved_loc_a: assert property ((rf_read_s and (rf_loc_in > 6'h1f
      && rf_loc_in < 6'h38)) |-> ##2 rf_err_out)
    else $error("reserved location was not refused");
  byte_size_a: assert property ((rf_read_s and (rf_size_in == 2'h0
      && rf_loc_in > 6'h0f)) |-> ##2 (rf_err_out && rf_rdata_out == 0))
    else $error("byte access above 15 was not refused");
  // Earlier alias requests still in flight would ack inside the window
  alias_slower_a: assert property ((sfr_read_s ##0 (!sv_q[0] && !sv_q[1]
      && !sv_q[2])) |-> ##1 !sfr_ack_out [*3] ##1 sfr_ack_out)
    else $error("alias read not answered exactly four cycles later");
  region_reset_a: assert property ($rose(reset_n_in)
      |-> data_pointer_region_out == 8'h01)
    else $error("region byte not 01h after reset");
  xdata_map_a: assert property (map_valid_in && map_space_in == 2'h1
      |=> map_valid_out && map_addr_out ==
      {$past(data_pointer_region_out), $past(map_offset_in)})
    else $error("external data address not formed from region byte");
  code_map_a: assert property (map_valid_in && map_space_in == 2'h0
      |=> map_addr_out[23:16] == 8'hff)
    else $error("code read not directed to region FF");
  acc_alias_a: assert property (sfr_wr_en_in && !sfr_rd_en_in
      && sfr_addr_in == 9'h0e0 && !rf_wr_en_in
      |=> ff_q[3] == $past(sfr_wdata_in))
    else $error("accumulator alias write not in byte 11");
  stack_push_a: assert property (stack_push_in && !stack_pop_in
      && !sfr_wr_en_in && !rf_wr_en_in
      |=> stack_pointer_out == $past(stack_pointer_out) + 16'h0001)
    else $error("push did not advance the stack pointer");
  bank_mem_a: assert property (mem_rd_en_in && !mem_wr_en_in
      && mem_addr_in < 24'h000020 |-> ##2 (mem_ack_out && mem_hit_out))
    else $error("bank RAM not reachable through memory view");
endmodule

// ==== shared/rbf_pkg.sv ====
// Constants and types shared by the banked register file design
package rbf_pkg;
  localparam int CLK_PERIOD_NS = 20;
  // One state is two core clock periods
  localparam int STATE_NS      = 40;
  localparam int STATE_CYCLES  =
    (STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RF_LAT        = 2;
  localparam int SFR_LAT       = RF_LAT + STATE_CYCLES;
  localparam int LOC_W         = 6;
  localparam int SFR_W         = 9;
  localparam int ADDR_W        = 24;
  localparam int OFF_W         = 16;
  localparam int ROW_LSB       = 3;
  localparam int ROW_W         = 2;
  localparam int LANE_W        = 3;
  localparam int FF_BYTES      = 32;

  localparam logic [5:0] BANK_END       = 6'h07;
  localparam logic [5:0] FF_BASE        = 6'h08;
  localparam logic [5:0] BYTE_END       = 6'h0f;
  localparam logic [5:0] LOW_END        = 6'h1f;
  localparam logic [5:0] LOC_OPB        = 6'h0a;
  localparam logic [5:0] LOC_ACC        = 6'h0b;
  localparam logic [5:0] LOC_XDP_BASE   = 6'h38;
  localparam logic [5:0] LOC_REGION     = 6'h39;
  localparam logic [5:0] LOC_PTR_HI     = 6'h3a;
  localparam logic [5:0] LOC_PTR_LO     = 6'h3b;
  localparam logic [5:0] LOC_STK_BASE   = 6'h3c;
  localparam logic [5:0] LOC_STK_HI     = 6'h3e;
  localparam logic [5:0] LOC_STK_LO     = 6'h3f;
  localparam logic [5:0] FF_HI_SLOT     = 6'h18;

  localparam logic [8:0] SFR_STK_LO     = 9'h081;
  localparam logic [8:0] SFR_PTR_LO     = 9'h082;
  localparam logic [8:0] SFR_PTR_HI     = 9'h083;
  localparam logic [8:0] SFR_REGION     = 9'h084;
  localparam logic [8:0] SFR_STK_HI     = 9'h0be;
  localparam logic [8:0] SFR_ACC        = 9'h0e0;
  localparam logic [8:0] SFR_OPB        = 9'h0f0;

  localparam logic [7:0]  REGION_RESET  = 8'h01;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [7:0]  REGION_CODE   = 8'hff;
  localparam logic [7:0]  REGION_IDATA  = 8'h00;
  localparam logic [15:0] STACK_STEP    = 16'h0001;
  localparam logic [23:0] BANK_MEM_LIM  = 24'h000020;

  typedef enum logic [1:0] {
    SZ_BYTE  = 2'h0,
    SZ_WORD  = 2'h1,
    SZ_DWORD = 2'h2
  } rbf_size_e;

  typedef enum logic [1:0] {
    SPACE_CODE  = 2'h0,
    SPACE_XDATA = 2'h1,
    SPACE_IDATA = 2'h2,
    SPACE_SFR   = 2'h3
  } rbf_space_e;
endpackage

// ==== src/rbf_bank_ram.sv ====
// Byte-lane memory holding the four switchable register banks
module rbf_bank_ram
#(
  parameter int ROWS  = 4,
  parameter int LANES = 8
)
(
  input  wire logic                    clk_in,
  input  wire logic                    we_in,
  input  wire logic [$clog2(ROWS)-1:0] wr_row_in,
  input  wire logic [LANES-1:0]        be_in,
  input  wire logic [8*LANES-1:0]      wdata_in,
  input  wire logic [$clog2(ROWS)-1:0] rd_row_a_in,
  input  wire logic [$clog2(ROWS)-1:0] rd_row_b_in,
  output logic      [8*LANES-1:0]      rdata_a_out,
  output logic      [8*LANES-1:0]      rdata_b_out
);
  if (ROWS < 2 || LANES < 1)
  begin : g_chk
    $error("rbf_bank_ram needs at least two rows and one lane");
  end

  logic [8*LANES-1:0] mem_q [ROWS];

  // Contents are not reset: the banks are ordinary on-chip RAM
  always_ff @(posedge clk_in)
  begin
    for (int l = 0; l < LANES; l++)
    begin
      if (we_in && be_in[l])
      begin
        mem_q[wr_row_in][8*l +: 8] <= wdata_in[8*l +: 8];
      end
    end
    rdata_a_out <= mem_q[rd_row_a_in];
    rdata_b_out <= mem_q[rd_row_b_in];
  end
endmodule

// ==== bench/rbf_cpu_model.sv ====
// Behavioural model of the CPU side that issues stack moves
module rbf_cpu_model
(
  input  wire logic push_req_in,
  input  wire logic pop_req_in,
  output logic      stack_push_out,
  output logic      stack_pop_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Stack moves only come from push and pop; both together cancel
  assign stack_push_out = push_req_in & ~pop_req_in;
  assign stack_pop_out  = pop_req_in & ~push_req_in;
endmodule

// ==== bench/rbf_regfile_tb_top.sv ====
// Self-checking bench for the banked register file
module rbf_regfile_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_in = 1'h0;
  logic        reset_n_in = 1'h0;
  logic [1:0]  bank = 2'h0;
  logic        rf_rd = 1'h0, rf_wr = 1'h0, sfr_rd = 1'h0, sfr_wr = 1'h0;
  logic        mem_rd = 1'h0, mem_wr = 1'h0, map_vi = 1'h0;
  logic        push_req = 1'h0, pop_req = 1'h0, push, pop;
  logic [5:0]  rf_loc = 6'h0;
  logic [1:0]  rf_sz = 2'h0, map_sp = 2'h0;
  logic [31:0] rf_wd = 32'h0, rf_rdata;
  logic [8:0]  sfr_a = 9'h0;
  logic [7:0]  sfr_wd = 8'h0, mem_wd = 8'h0, sfr_rdata, mem_rdata, rgn;
  logic [23:0] mem_a = 24'h0, map_addr;
  logic [15:0] map_off = 16'h0, sp, dp;
  logic        rf_ack, rf_err, sfr_ack, sfr_hit, mem_ack, mem_hit, map_vo;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;

  rbf_regfile i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .bank_select_high_in(bank[1]), .bank_select_low_in(bank[0]),
    .rf_rd_en_in(rf_rd), .rf_wr_en_in(rf_wr), .rf_loc_in(rf_loc),
    .rf_size_in(rf_sz), .rf_wdata_in(rf_wd), .rf_ack_out(rf_ack),
    .rf_err_out(rf_err), .rf_rdata_out(rf_rdata),
    .sfr_rd_en_in(sfr_rd), .sfr_wr_en_in(sfr_wr), .sfr_addr_in(sfr_a),
    .sfr_wdata_in(sfr_wd), .sfr_ack_out(sfr_ack), .sfr_hit_out(sfr_hit),
    .sfr_rdata_out(sfr_rdata), .mem_rd_en_in(mem_rd),
    .mem_wr_en_in(mem_wr), .mem_addr_in(mem_a), .mem_wdata_in(mem_wd),
    .mem_ack_out(mem_ack), .mem_hit_out(mem_hit),
    .mem_rdata_out(mem_rdata), .map_valid_in(map_vi),
    .map_space_in(map_sp), .map_offset_in(map_off),
    .map_valid_out(map_vo), .map_addr_out(map_addr),
    .stack_push_in(push), .stack_pop_in(pop), .stack_pointer_out(sp),
    .legacy_data_pointer_out(dp), .data_pointer_region_out(rgn));

  rbf_cpu_model i_cpu (.push_req_in(push_req), .pop_req_in(pop_req),
    .stack_push_out(push), .stack_pop_out(pop));

  always #10 clk_in = ~clk_in;

  task automatic stop_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Generous ceiling; the full run needs well under 400 cycles
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // op is {read, write}; every task starts and ends just after an edge
  task automatic rf(input logic [1:0] op, input logic [5:0] loc,
                    input logic [1:0] sz, input logic [31:0] wd,
                    input logic er, input logic [31:0] exp);
    {rf_rd, rf_wr, rf_loc, rf_sz, rf_wd} = {op, loc, sz, wd};
    @(posedge clk_in);
    #1 {rf_rd, rf_wr} = 2'h0;
    @(posedge clk_in);
    #1 chk("rf_ack", 32'h1, {31'h0, rf_ack});
    chk("rf_err", {31'h0, er}, {31'h0, rf_err});
    chk("rf_rdata", exp, rf_rdata);
  endtask

  task automatic sfr(input logic [1:0] op, input logic [8:0] a,
                     input logic [7:0] wd, input logic ht,
                     input logic [7:0] exp);
    {sfr_rd, sfr_wr, sfr_a, sfr_wd} = {op, a, wd};
    @(posedge clk_in);
    #1 {sfr_rd, sfr_wr} = 2'h0;
    @(posedge clk_in);
    #1 chk("sfr_ack_early", 32'h0, {31'h0, sfr_ack});
    repeat (2) @(posedge clk_in);
    #1 chk("sfr_ack", 32'h1, {31'h0, sfr_ack});
    chk("sfr_hit", {31'h0, ht}, {31'h0, sfr_hit});
    chk("sfr_rdata", {24'h0, exp}, {24'h0, sfr_rdata});
  endtask

  task automatic mem(input logic [1:0] op, input logic [23:0] a,
                     input logic [7:0] wd, input logic ak,
                     input logic ht, input logic [7:0] exp);
    {mem_rd, mem_wr, mem_a, mem_wd} = {op, a, wd};
    @(posedge clk_in);
    #1 {mem_rd, mem_wr} = 2'h0;
    @(posedge clk_in);
    #1 chk("mem_ack", {31'h0, ak}, {31'h0, mem_ack});
    chk("mem_hit", {31'h0, ht}, {31'h0, mem_hit});
    chk("mem_rdata", {24'h0, exp}, {24'h0, mem_rdata});
  endtask

  task automatic map(input logic [1:0] s, input logic [23:0] exp);
    {map_vi, map_sp, map_off} = {1'h1, s, 16'h1280};
    @(posedge clk_in);
    #1 map_vi = 1'h0;
    chk("map_valid", 32'h1, {31'h0, map_vo});
    chk("map_addr", {8'h0, exp}, {8'h0, map_addr});
  endtask

  task automatic step(input logic [1:0] op, input logic [15:0] exp);
    {push_req, pop_req} = op;
    @(posedge clk_in);
    #1 {push_req, pop_req} = 2'h0;
    chk("stack_pointer", {16'h0, exp}, {16'h0, sp});
  endtask

  task automatic t_banks;
    for (int b = 0; b < 4; b++)
    begin
      bank = 2'(b);
      rf(2'h1, 6'h03, 2'h0, 32'(b + 48), 1'h0, 32'h0);
      mem(2'h2, 24'(b * 8 + 3), 8'h0, 1'h1, 1'h1, 8'(b + 48));
      mem(2'h1, 24'(b * 8 + 5), 8'(b + 80), 1'h1, 1'h1, 8'h0);
      rf(2'h2, 6'h05, 2'h0, 32'h0, 1'h0, 32'(b + 80));
    end
    mem(2'h2, 24'h20, 8'h0, 1'h1, 1'h0, 8'h0);
    mem(2'h1, 24'h20, 8'h9, 1'h0, 1'h0, 8'h0);
  endtask

  task automatic t_sizes;
    rf(2'h1, 6'h04, 2'h2, 32'h12345678, 1'h0, 32'h0);
    rf(2'h2, 6'h04, 2'h0, 32'h0, 1'h0, 32'h12);
    rf(2'h2, 6'h06, 2'h1, 32'h0, 1'h0, 32'h5678);
    rf(2'h1, 6'h1e, 2'h1, 32'hbeef, 1'h0, 32'h0);
    rf(2'h2, 6'h1c, 2'h2, 32'h0, 1'h0, 32'hbeef);
    rf(2'h1, 6'h10, 2'h0, 32'h1, 1'h1, 32'h0);
    rf(2'h2, 6'h05, 2'h1, 32'h0, 1'h1, 32'h0);
    rf(2'h2, 6'h39, 2'h0, 32'h0, 1'h1, 32'h0);
    rf(2'h2, 6'h28, 2'h2, 32'h0, 1'h1, 32'h0);
    rf(2'h2, 6'h08, 2'h3, 32'h0, 1'h1, 32'h0);
    rf(2'h1, 6'h0f, 2'h0, 32'hf1, 1'h0, 32'h0);
    rf(2'h2, 6'h0e, 2'h1, 32'h0, 1'h0, 32'h00f1);
  endtask

  task automatic t_alias;
    rf(2'h1, 6'h0b, 2'h0, 32'ha5, 1'h0, 32'h0);
    sfr(2'h2, 9'h0e0, 8'h0, 1'h1, 8'ha5);
    sfr(2'h1, 9'h0f0, 8'h3c, 1'h1, 8'h0);
    rf(2'h2, 6'h0a, 2'h0, 32'h0, 1'h0, 32'h3c);
    rf(2'h1, 6'h38, 2'h2, 32'h00abcdef, 1'h0, 32'h0);
    sfr(2'h2, 9'h084, 8'h0, 1'h1, 8'hab);
    sfr(2'h2, 9'h083, 8'h0, 1'h1, 8'hcd);
    sfr(2'h2, 9'h082, 8'h0, 1'h1, 8'hef);
    chk("legacy_pointer", 32'hcdef, {16'h0, dp});
    sfr(2'h2, 9'h1ff, 8'h0, 1'h0, 8'h0);
    map(2'h0, 24'hff1280);
    map(2'h1, 24'hab1280);
    map(2'h2, 24'h001280);
    map(2'h3, 24'h000080);
  endtask

  task automatic t_stack;
    rf(2'h1, 6'h3c, 2'h2, 32'h000012ff, 1'h0, 32'h0);
    step(2'h2, 16'h1300);
    sfr(2'h2, 9'h081, 8'h0, 1'h1, 8'h00);
    sfr(2'h2, 9'h0be, 8'h0, 1'h1, 8'h13);
    step(2'h1, 16'h12ff);
    rf(2'h2, 6'h3c, 2'h2, 32'h0, 1'h0, 32'h000012ff);
  endtask

  initial
  begin
    repeat (6) @(posedge clk_in);
    #1 reset_n_in = 1'h1;
    chk("region_reset", 32'h01, {24'h0, rgn});
    chk("stack_reset", 32'h0, {16'h0, sp});
    t_banks();
    t_sizes();
    t_alias();
    t_stack();
    stop_test();
  end
endmodule
